// ### rtl/epc_array.sv
// byte array storage, registered read port
`default_nettype none
module epc_array (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  input  wire logic [epc_pkg::IDX_W-1:0] raddr,
  output logic      [7:0]                rdata,
  input  wire logic                      we,
  input  wire logic [epc_pkg::IDX_W-1:0] waddr,
  input  wire logic [7:0]                wdata
);
  import epc_pkg::*;
  logic [7:0] mem [ARRAY_BYTES];

  always_ff @(posedge CLK_SYS) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ### rtl/epc_pkg.sv
// shared constants and types of the nonvolatile program control block
`default_nettype none
package epc_pkg;
  localparam logic [31:0] CTRL_ADDR     = 32'h0000001c;
  localparam logic [31:0] ARRAY_BASE    = 32'h00000140;
  localparam int          ARRAY_BYTES   = 128;
  localparam logic [31:0] ARRAY_SPAN    = 32'h00000200;
  localparam int          IDX_W         = 7;
  localparam int          BLK_LSB       = 5;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam int          POS_PGM       = 0;
  localparam int          POS_PUMP      = 1;
  localparam int          POS_ERASE_LO  = 2;
  localparam int          POS_ERASE_HI  = 3;
  localparam int          POS_CAPTURE   = 4;
  localparam int          POS_RC_SEL    = 5;

  typedef enum logic [1:0] {
    ERASE_NONE  = 2'b00,
    ERASE_BYTE  = 2'b01,
    ERASE_BLOCK = 2'b10,
    ERASE_BULK  = 2'b11
  } epc_erase_t;

  // bit 0 upward: pgm, pump, erase[1:0], capture, rc_sel, spare
  typedef struct packed {
    logic [1:0] spare;
    logic       rc_clock_select;
    logic       bus_capture_bit;
    epc_erase_t erase_select;
    logic       charge_pump_enable;
    logic       program_power_enable;
  } epc_ctrl_t;

  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b000,
    ENG_READ  = 3'b001,
    ENG_MERGE = 3'b011,
    ENG_SWEEP = 3'b010,
    ENG_DONE  = 3'b110
  } epc_eng_t;
endpackage
`default_nettype wire

// ### rtl/epc_sync.sv
// three-stage synchroniser with agreement filter
`default_nettype none
module epc_sync (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      level_out <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_out <= s3_ff;
    end
  end
endmodule
`default_nettype wire

// ### rtl/epc_top.sv
// program and erase control for the on-chip nonvolatile byte array
`default_nettype none
// What this block does
// - 128-byte array based at 0x0140
// - one control register at 0x001C
// - pump enable bit drives charge pump
// - no array voltage without power enable
// - erase field selects program/byte/block/bulk
// - byte erase clears only addressed byte
// - block erase covers aligned 32 bytes
// - bulk erase covers whole array
// - capture bit latches array write address/data
// - captured write inhibits array reads
// - capture clear gives normal reads; reset clears
// - rc select steps logic from RC
// - RC oscillator stopped in stop mode
// - power enable powers pump and array
// - power enable writable only while capture bit set
// - clearing capture clears power enable
module epc_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        RC_CLK,
  input  wire logic        STOP_MODE,
  output logic             PUMP_ON,
  output logic             ARRAY_HV_ON,
  output logic             RC_OSC_EN
);
  import epc_pkg::*;

  epc_ctrl_t          ctrl_ff;
  epc_ctrl_t          nxt_ctrl;
  epc_ctrl_t          wr_val;
  logic               wr_pend_ff;
  logic               wr_ctrl_ff;
  logic               wr_arr_ff;
  logic [IDX_W-1:0]   wr_idx_ff;
  logic [1:0]         rd_stage_ff;
  logic               rd_ctrl_ff;
  logic               rd_arr_ff;
  logic [IDX_W-1:0]   rd_idx_ff;
  logic               captured_ff;
  logic [IDX_W-1:0]   cap_idx_ff;
  logic [7:0]         cap_data_ff;
  epc_eng_t           eng_ff;
  epc_eng_t           nxt_eng;
  logic [IDX_W-1:0]   eng_addr_ff;
  logic [IDX_W-1:0]   nxt_eng_addr;
  logic [IDX_W-1:0]   eng_last_ff;
  logic [IDX_W-1:0]   nxt_eng_last;
  logic               rc_level;
  logic               rc_prev_ff;
  logic               step;
  logic               accept;
  logic [31:0]        addr_off;
  logic               hit_ctrl;
  logic               hit_arr;
  logic               arr_we;
  logic [7:0]         arr_wdata;
  logic [7:0]         arr_rdata;
  logic [IDX_W-1:0]   arr_raddr;
  logic               eng_busy;
  logic               wr_capture;

  // address phase decode
  assign accept   = HSEL & HTRANS[1] & HREADY;
  assign addr_off = HADDR - ARRAY_BASE;
  assign hit_ctrl = (HADDR == CTRL_ADDR);
  assign hit_arr  = (HADDR >= ARRAY_BASE) && (addr_off < ARRAY_SPAN);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_ff <= 1'b0;
      wr_ctrl_ff <= 1'b0;
      wr_arr_ff  <= 1'b0;
      wr_idx_ff  <= '0;
    end else begin
      wr_pend_ff <= accept & HWRITE;
      if (accept & HWRITE) begin
        wr_ctrl_ff <= hit_ctrl;
        wr_arr_ff  <= hit_arr;
        wr_idx_ff  <= addr_off[IDX_W+1:2];
      end
    end
  end

  // reads wait two cycles so the array word and the reply come from registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_stage_ff <= 2'd0;
      rd_ctrl_ff  <= 1'b0;
      rd_arr_ff   <= 1'b0;
      rd_idx_ff   <= '0;
    end else if (rd_stage_ff == 2'd1) begin
      rd_stage_ff <= 2'd2;
    end else if (rd_stage_ff == 2'd2) begin
      rd_stage_ff <= 2'd0;
    end else if (accept & ~HWRITE) begin
      rd_stage_ff <= 2'd1;
      rd_ctrl_ff  <= hit_ctrl;
      rd_arr_ff   <= hit_arr;
      rd_idx_ff   <= addr_off[IDX_W+1:2];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRDATA    <= 32'h00000000;
      HRESP     <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      if (rd_stage_ff == 2'd2) begin
        HREADYOUT <= 1'b1;
        if (rd_ctrl_ff) begin
          HRDATA <= {24'h000000, ctrl_ff};
        end else if (rd_arr_ff && !(ctrl_ff.bus_capture_bit && captured_ff)) begin
          HRDATA <= {24'h000000, arr_rdata};
        end else begin
          HRDATA <= 32'h00000000;
        end
      end else if (accept & ~HWRITE) begin
        HREADYOUT <= 1'b0;
      end
    end
  end

  // control register write
  assign wr_val = epc_ctrl_t'(HWDATA[7:0]);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_pend_ff && wr_ctrl_ff) begin
      nxt_ctrl.spare              = 2'b00;
      nxt_ctrl.charge_pump_enable = wr_val.charge_pump_enable;
      nxt_ctrl.erase_select       = wr_val.erase_select;
      nxt_ctrl.bus_capture_bit    = wr_val.bus_capture_bit;
      nxt_ctrl.rc_clock_select    = wr_val.rc_clock_select;
      if (ctrl_ff.bus_capture_bit) begin
        nxt_ctrl.program_power_enable = wr_val.program_power_enable;
      end
    end
    if (!nxt_ctrl.bus_capture_bit) begin
      nxt_ctrl.program_power_enable = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_ff <= epc_ctrl_t'(CTRL_RESET);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PUMP_ON     <= 1'b0;
      ARRAY_HV_ON <= 1'b0;
      RC_OSC_EN   <= 1'b0;
    end else begin
      PUMP_ON     <= nxt_ctrl.charge_pump_enable | nxt_ctrl.program_power_enable;
      ARRAY_HV_ON <= nxt_ctrl.program_power_enable;
      RC_OSC_EN   <= nxt_ctrl.rc_clock_select & ~STOP_MODE;
    end
  end

  // array write capture while the capture bit is set
  assign wr_capture = wr_pend_ff & wr_arr_ff & ctrl_ff.bus_capture_bit;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      captured_ff <= 1'b0;
      cap_idx_ff  <= '0;
      cap_data_ff <= 8'h00;
    end else if (!nxt_ctrl.bus_capture_bit) begin
      captured_ff <= 1'b0;
    end else if (wr_capture) begin
      captured_ff <= 1'b1;
      cap_idx_ff  <= wr_idx_ff;
      cap_data_ff <= HWDATA[7:0];
    end
  end

  // rc tick: rising edge of the synchronised oscillator
  epc_sync u_rc_sync (
    .CLK_SYS   (CLK_SYS),
    .RST       (RST),
    .async_in  (RC_CLK),
    .level_out (rc_level)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rc_prev_ff <= 1'b0;
    end else begin
      rc_prev_ff <= rc_level;
    end
  end

  assign step = ctrl_ff.rc_clock_select ? (rc_level & ~rc_prev_ff) : 1'b1;

  // program / erase engine, runs while power is applied to a captured byte
  always_comb begin
    nxt_eng      = eng_ff;
    nxt_eng_addr = eng_addr_ff;
    nxt_eng_last = eng_last_ff;
    if (!ctrl_ff.program_power_enable || !captured_ff) begin
      nxt_eng = ENG_IDLE;
    end else if (step) begin
      case (eng_ff)
        ENG_IDLE: begin
          case (ctrl_ff.erase_select)
            ERASE_NONE: begin
              nxt_eng      = ENG_READ;
              nxt_eng_addr = cap_idx_ff;
            end
            ERASE_BYTE: begin
              nxt_eng      = ENG_SWEEP;
              nxt_eng_addr = cap_idx_ff;
              nxt_eng_last = cap_idx_ff;
            end
            ERASE_BLOCK: begin
              nxt_eng      = ENG_SWEEP;
              nxt_eng_addr = {cap_idx_ff[IDX_W-1:BLK_LSB], 5'h00};
              nxt_eng_last = {cap_idx_ff[IDX_W-1:BLK_LSB], 5'h1f};
            end
            default: begin
              nxt_eng      = ENG_SWEEP;
              nxt_eng_addr = 7'h00;
              nxt_eng_last = 7'h7f;
            end
          endcase
        end
        ENG_READ: begin
          nxt_eng = ENG_MERGE;
        end
        ENG_MERGE: begin
          nxt_eng = ENG_DONE;
        end
        ENG_SWEEP: begin
          if (eng_addr_ff == eng_last_ff) begin
            nxt_eng = ENG_DONE;
          end else begin
            nxt_eng_addr = eng_addr_ff + 7'h01;
          end
        end
        ENG_DONE: begin
          nxt_eng = ENG_DONE;
        end
        default: begin
          nxt_eng = ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      eng_ff      <= ENG_IDLE;
      eng_addr_ff <= '0;
      eng_last_ff <= '0;
    end else begin
      eng_ff      <= nxt_eng;
      eng_addr_ff <= nxt_eng_addr;
      eng_last_ff <= nxt_eng_last;
    end
  end

  // programming can only clear bits; erase returns bytes to all ones
  assign eng_busy  = ctrl_ff.program_power_enable & captured_ff;
  assign arr_we    = eng_busy & step & ((eng_ff == ENG_SWEEP) | (eng_ff == ENG_MERGE));
  assign arr_wdata = (eng_ff == ENG_SWEEP) ? ERASED_BYTE : (arr_rdata & cap_data_ff);
  assign arr_raddr = eng_busy ? eng_addr_ff : rd_idx_ff;

  epc_array u_array (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .raddr   (arr_raddr),
    .rdata   (arr_rdata),
    .we      (arr_we),
    .waddr   (eng_addr_ff),
    .wdata   (arr_wdata)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_read_wait;
    !HREADYOUT ##1 !HREADYOUT ##1 HREADYOUT;
  endsequence

  a_hv_gated_power: assert property (!ctrl_ff.program_power_enable |-> !ARRAY_HV_ON)
    else $error("array voltage on without power enable");
  a_pump_follows: assert property (ctrl_ff.charge_pump_enable |-> PUMP_ON)
    else $error("pump off while pump enable set");
  a_power_pump_on: assert property (ARRAY_HV_ON |-> PUMP_ON)
    else $error("array power without pump");
  a_power_needs_capture: assert property (ctrl_ff.program_power_enable |-> ctrl_ff.bus_capture_bit)
    else $error("power enable set with capture clear");
  a_power_rise_cause: assert property ($rose(ctrl_ff.program_power_enable) |-> $past(ctrl_ff.bus_capture_bit))
    else $error("power enable set from capture-clear state");
  a_read_latency: assert property (accept && !HWRITE |=> s_read_wait)
    else $error("read answer timing wrong");
  a_read_inhibit: assert property ((rd_stage_ff == 2'd2) && rd_arr_ff && ctrl_ff.bus_capture_bit && captured_ff
                                   |=> HRDATA == 32'h00000000)
    else $error("array read not inhibited");
  a_capture_addr: assert property (wr_capture && nxt_ctrl.bus_capture_bit
                                   |=> captured_ff && cap_idx_ff == $past(wr_idx_ff))
    else $error("array write not captured");
  a_block_range: assert property (arr_we && (eng_ff == ENG_SWEEP) && ctrl_ff.erase_select == ERASE_BLOCK
                                  |-> eng_addr_ff[6:5] == cap_idx_ff[6:5])
    else $error("block erase outside block");
  a_byte_only: assert property (arr_we && (eng_ff == ENG_SWEEP) && ctrl_ff.erase_select == ERASE_BYTE
                                |-> eng_addr_ff == cap_idx_ff && arr_wdata == ERASED_BYTE)
    else $error("byte erase hit wrong byte");
  a_rc_stop: assert property (STOP_MODE |=> !RC_OSC_EN)
    else $error("rc oscillator running in stop mode");
  a_spare_zero: assert property (ctrl_ff.spare == 2'b00)
    else $error("spare control bits not zero");
  a_bulk_span: assert property ((eng_ff == ENG_SWEEP) && ctrl_ff.erase_select == ERASE_BULK |-> eng_last_ff == 7'h7f)
    else $error("bulk erase does not reach last byte");
  a_rc_enable: assert property (RC_OSC_EN |-> ctrl_ff.rc_clock_select)
    else $error("rc oscillator on without rc select");
endmodule
`default_nettype wire

// ### testbench/epc_rc_model.sv
// behavioural internal rc oscillator feeding the nonvolatile logic
`default_nettype none
module epc_rc_model (
  input  wire logic enable,
  output logic      rc_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rc_q = 1'b0;
  // runs unrelated to the bus clock, parks low while disabled
  always begin
    #9.3;
    rc_q <= enable ? ~rc_q : 1'b0;
  end
  assign rc_clk = rc_q;
endmodule
`default_nettype wire

// ### testbench/epc_top_tb.sv
// self-checking bench of the nonvolatile program control block
`default_nettype none
module epc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import epc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        stop_mode = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pump_on, array_hv_on, rc_osc_en, rc_clk;
  logic [7:0]  mem_exp [ARRAY_BYTES];
  logic [31:0] lfsr_q = 32'h28d5a772;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  epc_top epc_top_i (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RC_CLK(rc_clk), .STOP_MODE(stop_mode),
    .PUMP_ON(pump_on), .ARRAY_HV_ON(array_hv_on), .RC_OSC_EN(rc_osc_en));
  epc_rc_model epc_rc_model_i (.enable(rc_osc_en), .rc_clk(rc_clk));

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report;
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // which bytes an operation on target t touches
  function automatic logic hit(input logic [1:0] m, input int i, input int t);
    case (m)
      2'b10:   return (i >> BLK_LSB) == (t >> BLK_LSB);
      2'b11:   return 1'b1;
      default: return i == t;
    endcase
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 8'h00, v);
    check(v, {24'h0, e});
  endtask

  task automatic outs(input logic p, input logic h, input logic r);
    @(posedge clk_sys);
    check({29'h0, pump_on, array_hv_on, rc_osc_en}, {29'h0, p, h, r});
  endtask

  task automatic verify_all;
    for (int i = 0; i < ARRAY_BYTES; i++)
      rdc(ARRAY_BASE + 32'(4 * i), mem_exp[i]);
  endtask

  // one full software sequence: capture, write, power pulse, shut down
  task automatic nv_op(input logic [1:0] m, input int t, input logic [7:0] d, input logic rc, input int hold);
    logic [7:0] base;
    base = (8'h01 << POS_CAPTURE) | (8'h01 << POS_PUMP) | (8'(m) << POS_ERASE_LO) | (8'(rc) << POS_RC_SEL);
    wr(CTRL_ADDR, base);
    if (rc)
      repeat (30) @(posedge clk_sys);
    wr(ARRAY_BASE + 32'(4 * t), d);
    rdc(ARRAY_BASE + 32'(4 * t), 8'h00);
    outs(1'b1, 1'b0, rc);
    wr(CTRL_ADDR, base | (8'h01 << POS_PGM));
    outs(1'b1, 1'b1, rc);
    repeat (hold) @(posedge clk_sys);
    wr(CTRL_ADDR, base);
    outs(1'b1, 1'b0, rc);
    repeat (4) @(posedge clk_sys);
    wr(CTRL_ADDR, 8'h00);
    for (int i = 0; i < ARRAY_BYTES; i++)
      if (hit(m, i, t))
        mem_exp[i] = (m == 2'b00) ? (mem_exp[i] & d) : ERASED_BYTE;
    verify_all();
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(CTRL_ADDR, CTRL_RESET);
    outs(1'b0, 1'b0, 1'b0);
    rdc(32'h00001000, 8'h00);
    wr(CTRL_ADDR, 8'h13);
    rdc(CTRL_ADDR, 8'h12);
    outs(1'b1, 1'b0, 1'b0);
    wr(CTRL_ADDR, 8'h13);
    rdc(CTRL_ADDR, 8'h13);
    outs(1'b1, 1'b1, 1'b0);
    wr(CTRL_ADDR, 8'h03);
    rdc(CTRL_ADDR, 8'h02);
    outs(1'b1, 1'b0, 1'b0);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hff);
    rdc(CTRL_ADDR, 8'h3e);
    outs(1'b1, 1'b0, 1'b1);
    stop_mode <= 1'b1;
    outs(1'b1, 1'b0, 1'b1);
    outs(1'b1, 1'b0, 1'b0);
    stop_mode <= 1'b0;
    wr(CTRL_ADDR, 8'h00);
    for (int i = 0; i < ARRAY_BYTES; i++)
      mem_exp[i] = 8'hxx;
    nv_op(2'b11, 77, 8'h00, 1'b0, 300);
    nv_op(2'b00, 40, 8'h5a, 1'b0, 20);
    nv_op(2'b00, 40, 8'hf0, 1'b0, 20);
    nv_op(2'b10, 33, 8'h00, 1'b0, 100);
    nv_op(2'b00, 127, 8'h81, 1'b0, 20);
    nv_op(2'b01, 127, 8'h00, 1'b0, 20);
    wr(ARRAY_BASE + 32'd8, 8'h00);
    rdc(ARRAY_BASE + 32'd8, mem_exp[2]);
    nv_op(2'b00, 96, 8'h3c, 1'b1, 600);
    for (int k = 0; k < 6; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      nv_op(lfsr_q[9:8], int'(lfsr_q[22:16]), lfsr_q[7:0], 1'b0, 300);
    end
    final_report();
  end
endmodule
`default_nettype wire
